// file: core/scsp_pkg.sv
// package: register map, field layout, codes and timing constants for the clock select and prescale block
package scsp_pkg;
   // ==========================================================
   // register map (byte addresses, one aligned word each)
   localparam logic [7:0] ADDR_TRIM      = 8'h00;
   localparam logic [7:0] ADDR_DIVCTL    = 8'h04;
   localparam logic [7:0] ADDR_ASYNC     = 8'h08;
   localparam logic [7:0] ADDR_STATUS    = 8'h0c;
   // ==========================================================
   // field layout
   localparam int UNLOCK_BIT   = 7;
   localparam int EXTIN_BIT    = 6;
   localparam int RANGE_BIT    = 7;
   localparam int DIVSEL_W     = 4;
   localparam logic [3:0] DIVSEL_RST_DIV1 = 4'h0;
   localparam logic [3:0] DIVSEL_RST_DIV8 = 4'h3;
   localparam logic [3:0] DIVSEL_MAX      = 4'h8;
   localparam logic [2:0] UNLOCK_CYCLES   = 3'h4;
   // ==========================================================
   // clock source and start-up fuse codes
   localparam logic [3:0] SRC_EXT      = 4'h0;
   localparam logic [3:0] SRC_RC       = 4'h2;
   localparam logic [3:0] SRC_LF_FAST  = 4'h6;
   localparam logic [3:0] SRC_LF_SLOW  = 4'h7;
   localparam logic [1:0] SUT_NONE     = 2'h0;
   localparam logic [1:0] SUT_SHORT    = 2'h1;
   localparam logic [1:0] SUT_LONG     = 2'h2;
   // ==========================================================
   // timing: figures in their own units, counts derived at 40 MHz
   localparam int CLK_MHZ      = 40;
   localparam int WAKE_LF_FAST = 1024;
   localparam int WAKE_LF_SLOW = 32768;
   localparam int WAKE_EXT     = 6;
   localparam int RST_BASE     = 14;
   localparam int LF_SHORT_US  = 4000;
   localparam int EXT_SHORT_US = 4100;
   localparam int LONG_US      = 65000;
   localparam int LF_SHORT_CYC  = LF_SHORT_US * CLK_MHZ;
   localparam int EXT_SHORT_CYC = EXT_SHORT_US * CLK_MHZ;
   localparam int LONG_CYC      = LONG_US * CLK_MHZ;
   localparam int CNT_W         = 24;

   typedef enum {SCSP_RESET_WAIT, SCSP_RUN, SCSP_WAKE_WAIT} scsp_phase_t;

   typedef struct packed {
      logic [3:0] source_sel;
      logic [1:0] startup_sel;
      logic       clock_out_en;
      logic       div8_init;
      logic [7:0] factory_trim;
   } scsp_fuse_t;
endpackage : scsp_pkg

// file: core/scsp_top.sv
// top: clock source select, start-up delays, glitch-free prescaler, rc trim, axi4-lite slave
`timescale 1ns/1ps
module scsp_top #(
   parameter int LF_SHORT_CYC  = scsp_pkg::LF_SHORT_CYC,
   parameter int EXT_SHORT_CYC = scsp_pkg::EXT_SHORT_CYC,
   parameter int LONG_CYC      = scsp_pkg::LONG_CYC,
   parameter int WAKE_LF_SLOW  = scsp_pkg::WAKE_LF_SLOW
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // fuses and pins
   input  wire scsp_pkg::scsp_fuse_t fuses,
   input  wire logic                wake_req,
   // axi4-lite write address and data
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // axi4-lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // clock, ready, trim and timer oscillator outputs
   output logic                     sys_clk_en,
   output logic                     clock_output_pin,
   output logic                     clock_output_pin_oe,
   output logic                     core_ready,
   output logic [7:0]               rc_trim_out,
   output logic                     timer_osc_enable,
   output logic                     timer_osc_external_input_select
);
   // ==========================================================
   // registers
   logic [7:0]  rc_osc_trim_q;
   logic [3:0]  divider_select_q;
   logic [3:0]  div_active_q;
   logic [3:0]  div_pending_q;
   logic        div_pending_vld_q;
   logic        divider_change_unlock_q;
   logic [2:0]  unlock_cnt_q;
   logic        ext_in_q;
   logic        timer_en_q;
   logic [8:0]  ripple_q;
   logic        tick_q;
   logic [scsp_pkg::CNT_W-1:0] delay_q;
   scsp_pkg::scsp_phase_t phase_q;
   logic        wake_m1_q, wake_m2_q, wake_m3_q;
   logic        clock_output_pin_q, clock_output_pin_oe_q;

   // ==========================================================
   // axi4-lite handshake state
   logic        aw_hold_q, w_hold_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        wr_fire;
   logic        wr_lane0;
   logic [1:0]  wr_resp;

   assign wr_fire  = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign wr_lane0 = w_strb_q[0];

   always_ff @(posedge clk) begin
      if (srst) begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end else begin
         s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   always_comb begin
      if (aw_addr_q == scsp_pkg::ADDR_TRIM || aw_addr_q == scsp_pkg::ADDR_DIVCTL ||
          aw_addr_q == scsp_pkg::ADDR_ASYNC || aw_addr_q == scsp_pkg::ADDR_STATUS) begin
         wr_resp = 2'h0;
      end else begin
         wr_resp = 2'h2;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_resp;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // decoded register writes
   logic wr_trim, wr_div, wr_async;
   assign wr_trim  = wr_fire && wr_lane0 && aw_addr_q == scsp_pkg::ADDR_TRIM;
   assign wr_div   = wr_fire && wr_lane0 && aw_addr_q == scsp_pkg::ADDR_DIVCTL;
   assign wr_async = wr_fire && wr_lane0 && aw_addr_q == scsp_pkg::ADDR_ASYNC;

   // ==========================================================
   // rc trim: factory value reloaded on every reset, except when a trim write lands in the reload cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         rc_osc_trim_q <= 8'h00;
      end else if (phase_q == scsp_pkg::SCSP_RESET_WAIT && delay_q == '0 && !wr_trim) begin
         rc_osc_trim_q <= fuses.factory_trim;
      end else if (wr_trim) begin
         rc_osc_trim_q <= w_data_q[7:0];
      end
   end

   // ==========================================================
   // unlock window
   logic unlock_wr, divsel_wr;
   assign unlock_wr = wr_div && w_data_q[scsp_pkg::UNLOCK_BIT] && w_data_q[6:0] == 7'h00;
   assign divsel_wr = wr_div && !w_data_q[scsp_pkg::UNLOCK_BIT] && divider_change_unlock_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         divider_change_unlock_q <= 1'b0;
         unlock_cnt_q            <= 3'h0;
      end else if (divsel_wr) begin
         divider_change_unlock_q <= 1'b0;
      end else if (divider_change_unlock_q) begin
         unlock_cnt_q <= unlock_cnt_q + 3'h1;
         if (unlock_cnt_q + 3'h1 >= scsp_pkg::UNLOCK_CYCLES) begin
            divider_change_unlock_q <= 1'b0;
         end
      end else if (unlock_wr) begin
         divider_change_unlock_q <= 1'b1;
         unlock_cnt_q            <= 3'h0;
      end
   end

   // ==========================================================
   // divider select, reset by the div8 fuse
   always_ff @(posedge clk) begin
      if (srst) begin
         divider_select_q <= scsp_pkg::DIVSEL_RST_DIV1;
      end else if (phase_q == scsp_pkg::SCSP_RESET_WAIT && delay_q == '0) begin
         divider_select_q <= fuses.div8_init ? scsp_pkg::DIVSEL_RST_DIV8
                                             : scsp_pkg::DIVSEL_RST_DIV1;
      end else if (divsel_wr) begin
         divider_select_q <= w_data_q[scsp_pkg::DIVSEL_W-1:0];
      end
   end

   // ==========================================================
   // ripple prescaler on the undivided clock; tick is one enable per divided period
   logic       term;
   logic [8:0] div_mask;
   always_comb begin
      if (div_active_q > scsp_pkg::DIVSEL_MAX) begin
         div_mask = 9'h000;
      end else begin
         div_mask = 9'((10'h001 << div_active_q) - 10'h001);
      end
   end
   assign term = (ripple_q & div_mask) == div_mask;

   always_ff @(posedge clk) begin
      if (srst) begin
         ripple_q <= 9'h000;
         tick_q   <= 1'b0;
      end else begin
         ripple_q <= term ? 9'h000 : ripple_q + 9'h001;
         tick_q   <= term;
      end
   end

   // switch at the next old-rate period boundary: no short period, and the
   // period right after that boundary already runs at the new rate
   always_ff @(posedge clk) begin
      if (srst) begin
         div_active_q      <= scsp_pkg::DIVSEL_RST_DIV1;
         div_pending_q     <= scsp_pkg::DIVSEL_RST_DIV1;
         div_pending_vld_q <= 1'b0;
      end else if (div_pending_q != divider_select_q) begin
         div_pending_q     <= divider_select_q;
         div_pending_vld_q <= 1'b1;
      end else if (div_pending_vld_q && term) begin
         div_active_q      <= div_pending_q;
         div_pending_vld_q <= 1'b0;
      end
   end

   // ==========================================================
   // wake pin synchroniser
   always_ff @(posedge clk) begin
      if (srst) begin
         wake_m1_q <= 1'b0;
         wake_m2_q <= 1'b0;
         wake_m3_q <= 1'b0;
      end else begin
         wake_m1_q <= wake_req;
         wake_m2_q <= wake_m1_q;
         wake_m3_q <= wake_m2_q;
      end
   end

   // ==========================================================
   // start-up delay sequencer
   logic [scsp_pkg::CNT_W-1:0] reset_extra, wake_len;
   logic lf_src, ext_src;
   assign lf_src  = fuses.source_sel == scsp_pkg::SRC_LF_FAST ||
                    fuses.source_sel == scsp_pkg::SRC_LF_SLOW;
   assign ext_src = fuses.source_sel == scsp_pkg::SRC_EXT;

   always_comb begin
      reset_extra = scsp_pkg::CNT_W'(scsp_pkg::RST_BASE);
      if (fuses.startup_sel == scsp_pkg::SUT_SHORT) begin
         reset_extra = scsp_pkg::CNT_W'(scsp_pkg::RST_BASE + (ext_src ? EXT_SHORT_CYC
                                                                      : LF_SHORT_CYC));
      end else if (fuses.startup_sel == scsp_pkg::SUT_LONG) begin
         reset_extra = scsp_pkg::CNT_W'(scsp_pkg::RST_BASE + LONG_CYC);
      end
      if (lf_src) begin
         wake_len = (fuses.source_sel == scsp_pkg::SRC_LF_SLOW) ?
                    scsp_pkg::CNT_W'(WAKE_LF_SLOW) :
                    scsp_pkg::CNT_W'(scsp_pkg::WAKE_LF_FAST);
      end else begin
         wake_len = scsp_pkg::CNT_W'(scsp_pkg::WAKE_EXT);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         phase_q <= scsp_pkg::SCSP_RESET_WAIT;
         delay_q <= '1;
      end else begin
         case (phase_q)
            scsp_pkg::SCSP_RESET_WAIT: begin
               if (delay_q == '1) begin
                  delay_q <= reset_extra;
               end else if (delay_q == '0) begin
                  phase_q <= scsp_pkg::SCSP_RUN;
               end else begin
                  delay_q <= delay_q - 1'b1;
               end
            end
            scsp_pkg::SCSP_RUN: begin
               if (wake_m2_q && !wake_m3_q) begin
                  phase_q <= scsp_pkg::SCSP_WAKE_WAIT;
                  delay_q <= wake_len;
               end
            end
            default: begin
               if (delay_q <= 1) begin
                  phase_q <= scsp_pkg::SCSP_RUN;
                  delay_q <= '0;
               end else begin
                  delay_q <= delay_q - 1'b1;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // async timer control
   always_ff @(posedge clk) begin
      if (srst) begin
         ext_in_q   <= 1'b0;
         timer_en_q <= 1'b0;
      end else if (wr_async) begin
         ext_in_q   <= w_data_q[scsp_pkg::EXTIN_BIT];
         timer_en_q <= w_data_q[0] && fuses.source_sel == scsp_pkg::SRC_RC;
      end else if (fuses.source_sel != scsp_pkg::SRC_RC) begin
         timer_en_q <= 1'b0;
      end
   end

   // ==========================================================
   // clock output: divided clock, held low during reset
   // the pin enable follows the fuse even while reset is held
   always_ff @(posedge clk) begin
      clock_output_pin_oe_q <= fuses.clock_out_en;
      if (srst) begin
         clock_output_pin_q <= 1'b0;
      end else begin
         clock_output_pin_q <= tick_q ? !clock_output_pin_q : clock_output_pin_q;
      end
   end

   // ==========================================================
   // read channel
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            if (s_axi_araddr == scsp_pkg::ADDR_TRIM) begin
               s_axi_rdata <= {24'h000000, rc_osc_trim_q};
            end else if (s_axi_araddr == scsp_pkg::ADDR_DIVCTL) begin
               s_axi_rdata <= {24'h000000, divider_change_unlock_q, 3'h0, divider_select_q};
            end else if (s_axi_araddr == scsp_pkg::ADDR_ASYNC) begin
               s_axi_rdata <= {24'h000000, 1'b0, ext_in_q, 5'h00, timer_en_q};
            end else if (s_axi_araddr == scsp_pkg::ADDR_STATUS) begin
               s_axi_rdata <= {24'h000000, div_pending_vld_q, 2'h0,
                               phase_q == scsp_pkg::SCSP_RUN, div_active_q};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'h2;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // outputs
   logic ready_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= phase_q == scsp_pkg::SCSP_RUN;
      end
   end
   assign sys_clk_en                      = tick_q;
   assign clock_output_pin                = clock_output_pin_q;
   assign clock_output_pin_oe             = clock_output_pin_oe_q;
   assign core_ready                      = ready_q;
   assign rc_trim_out                     = rc_osc_trim_q;
   assign timer_osc_enable                = timer_en_q;
   assign timer_osc_external_input_select = ext_in_q;
endmodule : scsp_top

// file: verif/scsp_assertions.sv
// checker: port-level assertions for the clock select and prescale block
`timescale 1ns/1ps
module scsp_assertions (
   // clock and reset
   input wire logic                 clk,
   input wire logic                 srst,
   // observed inputs
   input wire scsp_pkg::scsp_fuse_t fuses,
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_bready,
   input wire logic                 s_axi_rready,
   // observed outputs
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_bvalid,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_rvalid,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic                 sys_clk_en,
   input wire logic                 clock_output_pin,
   input wire logic                 clock_output_pin_oe,
   input wire logic                 core_ready,
   input wire logic [7:0]           rc_trim_out,
   input wire logic                 timer_osc_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ==========================================================
   // cycles since reset release, saturating
   logic [4:0] since_q;
   always_ff @(posedge clk) begin
      if (srst) since_q <= 5'h00;
      else if (since_q != 5'h1f) since_q <= since_q + 5'h01;
   end
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence aw_taken;
      s_axi_awvalid && s_axi_awready;
   endsequence
   // ==========================================================
   // properties
   AST_OE_FOLLOWS_FUSE: assert property (!$past(srst) && !$past(srst, 2) |-> clock_output_pin_oe == $past(fuses.clock_out_en))
      else $error("clock output enable differs from fuse");
   AST_PIN_ON_PULSE: assert property ($changed(clock_output_pin) |-> sys_clk_en || $past(sys_clk_en))
      else $error("clock output moved without a divided pulse");
   AST_TIMER_RC_ONLY: assert property (timer_osc_enable |-> fuses.source_sel == scsp_pkg::SRC_RC)
      else $error("timer oscillator on without rc source");
   AST_READY_DELAY: assert property (core_ready |-> since_q >= 5'd13)
      else $error("core ready before base start-up delay");
   AST_TRIM_LOADED: assert property ($rose(core_ready) |-> ##[0:4] rc_trim_out == fuses.factory_trim)
      else $error("factory trim not loaded");
   AST_READ_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   AST_AW_PULSE: assert property (aw_taken |=> !s_axi_awready)
      else $error("write address ready held");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule : scsp_assertions

// file: verif/scsp_source_model.sv
// partner: clock source and fuse strap model
`timescale 1ns/1ps
module scsp_source_model (
   // clock and reset
   input wire logic                 clk,
   input wire logic                 srst,
   // requested straps
   input wire scsp_pkg::scsp_fuse_t fuse_req,
   // wake request from the bench
   input wire logic                 wake_go,
   // to the block
   output scsp_pkg::scsp_fuse_t     fuses,
   output logic                     wake_req
);
   // source straps only change while the block is held in reset
   always_ff @(posedge clk) begin
      if (srst) fuses <= fuse_req;
   end
   // wake line idles low until the bench raises it
   assign wake_req = wake_go;
endmodule : scsp_source_model

// file: verif/system_clock_select_prescale_test.sv
// testbench: register rows, prescaler sweep, unlock hazards and second reset
`timescale 1ns/1ps
module system_clock_select_prescale_test;
   // ==========================================================
   // signals
   logic clk, srst, wake_req, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sys_clk_en, clock_output_pin, clock_output_pin_oe;
   logic core_ready, timer_osc_enable, timer_osc_external_input_select, wake_go;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rc_trim_out;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   scsp_pkg::scsp_fuse_t fuses, fuse_req;
   int error_cnt, checks_done, cyc, n;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
      logic [1:0]  resp;
   } scsp_row_t;
   localparam scsp_row_t ROWS [5] = '{
      '{8'h00, 32'h7f, 32'h7f, 2'h0},
      '{8'h00, 32'h80, 32'h80, 2'h0},
      '{8'h00, 32'h00, 32'h00, 2'h0},
      '{8'h08, 32'h41, 32'h41, 2'h0},
      '{8'h10, 32'h55, 32'h00, 2'h2}};
   scsp_source_model i_src (.clk(clk), .srst(srst), .fuse_req(fuse_req), .wake_go(wake_go),
                            .fuses(fuses), .wake_req(wake_req));
   scsp_top #(.LF_SHORT_CYC(20), .EXT_SHORT_CYC(20), .LONG_CYC(20), .WAKE_LF_SLOW(20)) i_dut (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   // called right after a clock edge; bready stays high, so a second write
   // starts at the edge of the first response and lands inside the unlock window
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid === 1'b1));
      r = s_axi_bresp;
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid === 1'b1));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read
   task automatic start(input scsp_pkg::scsp_fuse_t f);
      fuse_req <= f;
      srst <= 1'b1;
      repeat (20) @(posedge clk);
      check(clock_output_pin_oe, f.clock_out_en, "clock out in reset");
      srst <= 1'b0;
      while (core_ready !== 1'b1) @(posedge clk);
   endtask : start
   task automatic period();
      n = 0;
      @(posedge clk);
      while (sys_clk_en !== 1'b1) @(posedge clk);
      do begin
         @(posedge clk);
         n++;
      end while (sys_clk_en !== 1'b1);
   endtask : period
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         results();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h24;
      wake_go = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      fuse_req = '{scsp_pkg::SRC_RC, scsp_pkg::SUT_NONE, 1'b1, 1'b1, 8'h5a};
      start('{scsp_pkg::SRC_RC, scsp_pkg::SUT_NONE, 1'b1, 1'b1, 8'h5a});
      axi_read(scsp_pkg::ADDR_DIVCTL);
      check(d, 32'h3, "divider reset");
      axi_read(scsp_pkg::ADDR_TRIM);
      check(d, 32'h5a, "trim reset");
      check(clock_output_pin_oe, 1'b1, "clock out enable");
      foreach (ROWS[i]) begin
         axi_write(ROWS[i].addr, ROWS[i].wdata);
         check(r, ROWS[i].resp, "write response");
         axi_read(ROWS[i].addr);
         check(d, ROWS[i].rexp, "read value");
         check(r, ROWS[i].resp, "read response");
      end
      check(timer_osc_enable, 1'b1, "timer on with rc");
      for (int c = 9; c >= 0; c--) begin
         axi_write(scsp_pkg::ADDR_DIVCTL, 32'h80);
         axi_write(scsp_pkg::ADDR_DIVCTL, 32'(c));
         repeat (600) @(posedge clk);
         period();
         check(n, (c < 9) ? (1 << c) : 1, "divided period");
         axi_read(scsp_pkg::ADDR_STATUS);
         check(d & 32'hf, 32'(c), "active code");
      end
      for (int k = 0; k < 2; k++) begin
         axi_write(scsp_pkg::ADDR_DIVCTL, k ? 32'h80 : 32'h81);
         repeat (k * 10) @(posedge clk);
         axi_write(scsp_pkg::ADDR_DIVCTL, 32'h5);
         axi_read(scsp_pkg::ADDR_DIVCTL);
         check(d, 32'h0, "locked divider");
      end
      start('{scsp_pkg::SRC_EXT, scsp_pkg::SUT_LONG, 1'b0, 1'b0, 8'ha5});
      axi_read(scsp_pkg::ADDR_DIVCTL);
      check(d, 32'h0, "divider reset no div8");
      check(clock_output_pin_oe, 1'b0, "clock out off");
      axi_write(scsp_pkg::ADDR_ASYNC, 32'h41);
      repeat (2) @(posedge clk);
      check(timer_osc_enable, 1'b0, "timer off with ext");
      check(timer_osc_external_input_select, 1'b1, "timer ext input");
      // wake from sleep on the external clock holds the core for its start-up count
      wake_go <= 1'b1;
      while (core_ready !== 1'b0) @(posedge clk);
      n = 0;
      while (core_ready !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      check(n, scsp_pkg::WAKE_EXT, "wake wait");
      results();
   end
endmodule : system_clock_select_prescale_test
bind scsp_top scsp_assertions i_chk (.*);
